// *** hw/rrfp_pkg.sv ***
package rrfp_pkg;
   // frame layout, byte offsets within the 64-byte header
   localparam logic [6:0]  OFS_SOH       = 7'h00;
   localparam logic [6:0]  OFS_REV       = 7'h02;
   localparam logic [6:0]  OFS_OP        = 7'h03;
   localparam logic [6:0]  OFS_STATUS    = 7'h05;
   localparam logic [6:0]  OFS_FLAGS     = 7'h06;
   localparam logic [6:0]  OFS_LEN       = 7'h08;
   localparam logic [6:0]  OFS_START     = 7'h0c;
   localparam logic [6:0]  OFS_CRC_FIRST = 7'h02;
   localparam logic [6:0]  OFS_CRC_LAST  = 7'h3d;
   localparam logic [6:0]  OFS_HCK       = 7'h3e;
   localparam logic [6:0]  OFS_HDR_LAST  = 7'h3f;
   // field values
   localparam logic [15:0] SOH_MARKER    = 16'ha1ec;
   localparam logic [7:0]  REVISION      = 8'h03;
   localparam logic [7:0]  OP_READ       = 8'h03;
   localparam logic [15:0] RSP_FLAGS     = 16'h0001;
   localparam logic [15:0] CRC_POLY      = 16'h1021;
   localparam logic [15:0] CRC_INIT      = 16'h0000;
   // status byte of the answer
   localparam logic [7:0]  ST_OK         = 8'h00;
   localparam logic [7:0]  ST_BAD_CKSUM  = 8'hfb;
   localparam logic [7:0]  ST_ZERO_LEN   = 8'hfd;
   localparam logic [7:0]  ST_UNKNOWN    = 8'hff;
   // connections and inactivity timing
   localparam int          CONN_MAX      = 5;
   localparam int          CONN_ID_W     = 3;
   localparam int          TIMEOUT_S     = 10;
   localparam int          CLK_HZ        = 25_000_000;
   localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_S * CLK_HZ;
   localparam int          TMR_W         = 28;
   // network settings words; writing the last one applies them all
   localparam int          NET_WORDS     = 6;
   localparam logic [2:0]  NET_APPLY_SEL = 3'h5;

   typedef enum logic [2:0] {st_rx, st_eval, st_hdr, st_dreq, st_dwait, st_dcap, st_dhi, st_dlo} rrfp_state_e;
endpackage : rrfp_pkg

// *** hw/rrfp_crc_step.sv ***
`timescale 1ns/1ps
// one byte of a msb-first crc-16, no reflection, no final xor
module rrfp_crc_step #(
   parameter logic [15:0] POLY = rrfp_pkg::CRC_POLY
) (
   // running value and next byte
   input  wire logic [15:0] crc_in,
   input  wire logic [7:0]  byte_in,
   // updated value
   output logic      [15:0] crc_out
);
   always_comb begin
      logic [15:0] c;
      c = crc_in ^ {byte_in, 8'h00};
      for (int b = 0; b < 8; b++) begin
         c = c[15] ? ({c[14:0], 1'b0} ^ POLY) : {c[14:0], 1'b0};
      end
      crc_out = c;
   end
endmodule : rrfp_crc_step

// *** hw/rrfp_parser.sv ***
`timescale 1ns/1ps
module rrfp_parser #(
   parameter int unsigned TIMEOUT_CYCLES = rrfp_pkg::TIMEOUT_CYCLES
) (
   // clock and reset
   input  wire logic                                core_clk,
   input  wire logic                                rst_n,
   // command bytes from the control connections
   input  wire logic                                cmd_valid,
   input  wire logic [7:0]                          cmd_data,
   input  wire logic [rrfp_pkg::CONN_ID_W-1:0]      cmd_conn,
   output logic                                     cmd_ready,
   // answer bytes to the control connections
   output logic                                     rsp_valid,
   output logic      [7:0]                          rsp_data,
   output logic      [rrfp_pkg::CONN_ID_W-1:0]      rsp_conn,
   output logic                                     rsp_last,
   input  wire logic                                rsp_ready,
   // register set, data one cycle after the read enable
   output logic                                     reg_rd_en,
   output logic      [15:0]                         reg_rd_index,
   input  wire logic [15:0]                         reg_rd_data,
   // connection bookkeeping
   input  wire logic                                conn_open,
   input  wire logic                                conn_gone,
   input  wire logic [rrfp_pkg::CONN_ID_W-1:0]      conn_id,
   output logic      [rrfp_pkg::CONN_MAX-1:0]       conn_active,
   output logic      [rrfp_pkg::CONN_MAX-1:0]       conn_timeout,
   // network settings, staged then applied together
   input  wire logic                                net_wr,
   input  wire logic [2:0]                          net_sel,
   input  wire logic [15:0]                         net_data,
   output logic      [rrfp_pkg::NET_WORDS*16-1:0]   net_active
);
   localparam int TW = rrfp_pkg::TMR_W;
   localparam logic [TW-1:0] TMR_LAST = TW'(TIMEOUT_CYCLES - 1);

   typedef struct packed {
      rrfp_pkg::rrfp_state_e                      state;
      logic [6:0]                                 idx;
      logic [rrfp_pkg::CONN_ID_W-1:0]             conn;
      logic [15:0]                                soh;
      logic [7:0]                                 rev;
      logic [7:0]                                 op;
      logic [31:0]                                len;
      logic [15:0]                                start;
      logic [15:0]                                hck;
      logic [15:0]                                crc;
      logic [7:0]                                 status;
      logic [30:0]                                words_left;
      logic [15:0]                                rd_index;
      logic [15:0]                                word;
      logic                                       rsp_valid;
      logic [7:0]                                 rsp_data;
      logic                                       rsp_last;
      logic [rrfp_pkg::CONN_ID_W-1:0]             rsp_conn;
      logic                                       reg_rd_en;
      logic [rrfp_pkg::CONN_MAX-1:0][TW-1:0]      timer;
      logic [rrfp_pkg::CONN_MAX-1:0]              active;
      logic [rrfp_pkg::CONN_MAX-1:0]              timeout;
      logic [rrfp_pkg::NET_WORDS-1:0][15:0]       net_stage;
      logic [rrfp_pkg::NET_WORDS-1:0][15:0]       net_live;
   } rrfp_state_s;

   rrfp_state_s s;
   rrfp_state_s next_s;
   logic        slot;
   logic [7:0]  hdr_byte;
   logic [31:0] len_out;
   logic [15:0] crc_rx;
   logic [15:0] crc_tx;

   assign cmd_ready    = (s.state == rrfp_pkg::st_rx);
   assign slot         = !s.rsp_valid || rsp_ready;
   assign rsp_valid    = s.rsp_valid;
   assign rsp_data     = s.rsp_data;
   assign rsp_conn     = s.rsp_conn;
   assign rsp_last     = s.rsp_last;
   assign reg_rd_en    = s.reg_rd_en;
   assign reg_rd_index = s.rd_index;
   assign conn_active  = s.active;
   assign conn_timeout = s.timeout;
   assign net_active   = s.net_live;

   // same step serves the received header and the answer header
   rrfp_crc_step u_crc_rx (.crc_in(s.crc), .byte_in(cmd_data), .crc_out(crc_rx));
   rrfp_crc_step u_crc_tx (.crc_in(s.crc), .byte_in(hdr_byte), .crc_out(crc_tx));

   // answer header bytes; length reports the bytes actually returned
   always_comb begin
      len_out  = {s.words_left, 1'b0};
      hdr_byte = 8'h00;
      case (s.idx)
         rrfp_pkg::OFS_SOH:            hdr_byte = rrfp_pkg::SOH_MARKER[15:8];
         rrfp_pkg::OFS_SOH + 7'd1:     hdr_byte = rrfp_pkg::SOH_MARKER[7:0];
         rrfp_pkg::OFS_REV:            hdr_byte = rrfp_pkg::REVISION;
         rrfp_pkg::OFS_OP:             hdr_byte = s.op;
         rrfp_pkg::OFS_STATUS:         hdr_byte = s.status;
         rrfp_pkg::OFS_FLAGS:          hdr_byte = rrfp_pkg::RSP_FLAGS[15:8];
         rrfp_pkg::OFS_FLAGS + 7'd1:   hdr_byte = rrfp_pkg::RSP_FLAGS[7:0];
         rrfp_pkg::OFS_LEN:            hdr_byte = len_out[31:24];
         rrfp_pkg::OFS_LEN + 7'd1:     hdr_byte = len_out[23:16];
         rrfp_pkg::OFS_LEN + 7'd2:     hdr_byte = len_out[15:8];
         rrfp_pkg::OFS_LEN + 7'd3:     hdr_byte = len_out[7:0];
         rrfp_pkg::OFS_START:          hdr_byte = s.rd_index[15:8];
         rrfp_pkg::OFS_START + 7'd1:   hdr_byte = s.rd_index[7:0];
         rrfp_pkg::OFS_HCK:            hdr_byte = s.crc[15:8];
         rrfp_pkg::OFS_HDR_LAST:       hdr_byte = s.crc[7:0];
         default:                      hdr_byte = 8'h00;
      endcase
   end

   always_comb begin
      next_s           = s;
      next_s.reg_rd_en = 1'b0;
      next_s.timeout   = '0;
      if (rsp_ready) begin
         next_s.rsp_valid = 1'b0;
      end
      // one inactivity timer per connection
      for (int i = 0; i < rrfp_pkg::CONN_MAX; i++) begin
         if (s.active[i]) begin
            if (s.timer[i] == TMR_LAST) begin
               next_s.active[i]  = 1'b0;
               next_s.timeout[i] = 1'b1;
            end else begin
               next_s.timer[i] = s.timer[i] + 1'b1;
            end
         end
         if (cmd_valid && cmd_ready && cmd_conn == 3'(i)) begin
            next_s.timer[i] = '0;
         end
         if (conn_gone && conn_id == 3'(i)) begin
            next_s.active[i] = 1'b0;
         end
         if (conn_open && conn_id == 3'(i)) begin
            next_s.active[i] = 1'b1;
            next_s.timer[i]  = '0;
         end
      end
      // staged settings go live together on the apply word
      if (net_wr && 32'(net_sel) < rrfp_pkg::NET_WORDS) begin
         next_s.net_stage[net_sel] = net_data;
         if (net_sel == rrfp_pkg::NET_APPLY_SEL) begin
            next_s.net_live = next_s.net_stage;
         end
      end
      case (s.state)
         rrfp_pkg::st_rx: begin
            if (cmd_valid) begin
               if (s.idx == rrfp_pkg::OFS_SOH) begin
                  next_s.conn = cmd_conn;
                  next_s.crc  = rrfp_pkg::CRC_INIT;
               end
               // unlisted offsets are dropped on purpose
               if (s.idx <= rrfp_pkg::OFS_SOH + 7'd1) begin
                  next_s.soh = {s.soh[7:0], cmd_data};
               end else if (s.idx == rrfp_pkg::OFS_REV) begin
                  next_s.rev = cmd_data;
               end else if (s.idx == rrfp_pkg::OFS_OP) begin
                  next_s.op = cmd_data;
               end else if (s.idx >= rrfp_pkg::OFS_LEN && s.idx <= rrfp_pkg::OFS_LEN + 7'd3) begin
                  next_s.len = {s.len[23:0], cmd_data};
               end else if (s.idx == rrfp_pkg::OFS_START || s.idx == rrfp_pkg::OFS_START + 7'd1) begin
                  next_s.start = {s.start[7:0], cmd_data};
               end else if (s.idx >= rrfp_pkg::OFS_HCK) begin
                  next_s.hck = {s.hck[7:0], cmd_data};
               end
               if (s.idx >= rrfp_pkg::OFS_CRC_FIRST && s.idx <= rrfp_pkg::OFS_CRC_LAST) begin
                  next_s.crc = crc_rx;
               end
               if (s.idx == rrfp_pkg::OFS_HDR_LAST) begin
                  next_s.idx   = '0;
                  next_s.state = rrfp_pkg::st_eval;
               end else begin
                  next_s.idx = s.idx + 7'd1;
               end
            end
         end
         rrfp_pkg::st_eval: begin
            next_s.words_left = '0;
            if (s.crc != s.hck) begin
               next_s.status = rrfp_pkg::ST_BAD_CKSUM;
            end else if (s.soh != rrfp_pkg::SOH_MARKER || s.rev != rrfp_pkg::REVISION
                         || s.op != rrfp_pkg::OP_READ) begin
               next_s.status = rrfp_pkg::ST_UNKNOWN;
            end else if (s.len == 32'h0000_0000) begin
               next_s.status = rrfp_pkg::ST_ZERO_LEN;
            end else begin
               next_s.status     = rrfp_pkg::ST_OK;
               next_s.words_left = s.len[31:1];
            end
            next_s.rd_index = s.start;
            next_s.crc      = rrfp_pkg::CRC_INIT;
            next_s.state    = rrfp_pkg::st_hdr;
         end
         rrfp_pkg::st_hdr: begin
            if (slot) begin
               next_s.rsp_valid = 1'b1;
               next_s.rsp_data  = hdr_byte;
               next_s.rsp_conn  = s.conn;
               next_s.rsp_last  = (s.idx == rrfp_pkg::OFS_HDR_LAST) && (s.words_left == '0);
               if (s.idx >= rrfp_pkg::OFS_CRC_FIRST && s.idx <= rrfp_pkg::OFS_CRC_LAST) begin
                  next_s.crc = crc_tx;
               end
               if (s.idx == rrfp_pkg::OFS_HDR_LAST) begin
                  next_s.idx   = '0;
                  next_s.state = (s.words_left == '0) ? rrfp_pkg::st_rx : rrfp_pkg::st_dreq;
               end else begin
                  next_s.idx = s.idx + 7'd1;
               end
            end
         end
         rrfp_pkg::st_dreq: begin
            next_s.reg_rd_en = 1'b1;
            next_s.state     = rrfp_pkg::st_dwait;
         end
         rrfp_pkg::st_dwait: begin
            next_s.state = rrfp_pkg::st_dcap;
         end
         rrfp_pkg::st_dcap: begin
            next_s.word       = reg_rd_data;
            next_s.rd_index   = s.rd_index + 16'd1;
            next_s.words_left = s.words_left - 31'd1;
            next_s.state      = rrfp_pkg::st_dhi;
         end
         rrfp_pkg::st_dhi: begin
            if (slot) begin
               next_s.rsp_valid = 1'b1;
               next_s.rsp_data  = s.word[15:8];
               next_s.rsp_last  = 1'b0;
               next_s.state     = rrfp_pkg::st_dlo;
            end
         end
         rrfp_pkg::st_dlo: begin
            if (slot) begin
               next_s.rsp_valid = 1'b1;
               next_s.rsp_data  = s.word[7:0];
               next_s.rsp_last  = (s.words_left == '0);
               next_s.state     = (s.words_left == '0) ? rrfp_pkg::st_rx : rrfp_pkg::st_dreq;
            end
         end
         default: begin
            next_s.state = rrfp_pkg::st_rx;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // the second marker byte is due only once the sink has taken the first
   property p_marker_first;
      (s.state == rrfp_pkg::st_hdr && slot && s.idx == rrfp_pkg::OFS_SOH)
         |=> (rsp_valid && rsp_data == rrfp_pkg::SOH_MARKER[15:8])
         ##1 (!$past(rsp_ready) || rsp_data == rrfp_pkg::SOH_MARKER[7:0]);
   endproperty
   a_marker_first: assert property (p_marker_first) else $error("answer marker wrong");
   property p_bad_cksum;
      (s.state == rrfp_pkg::st_eval && s.crc != s.hck) |=> s.status == rrfp_pkg::ST_BAD_CKSUM && s.words_left == '0;
   endproperty
   a_bad_cksum: assert property (p_bad_cksum) else $error("checksum mismatch not reported");
   property p_unknown_op;
      (s.state == rrfp_pkg::st_eval && s.crc == s.hck && (s.op != rrfp_pkg::OP_READ || s.rev != rrfp_pkg::REVISION))
         |=> s.status == rrfp_pkg::ST_UNKNOWN;
   endproperty
   a_unknown_op: assert property (p_unknown_op) else $error("unknown operation not reported");
   property p_zero_len;
      (s.state == rrfp_pkg::st_eval && s.crc == s.hck && s.soh == rrfp_pkg::SOH_MARKER
       && s.rev == rrfp_pkg::REVISION && s.op == rrfp_pkg::OP_READ && s.len == 32'h0000_0000)
         |=> s.status == rrfp_pkg::ST_ZERO_LEN;
   endproperty
   a_zero_len: assert property (p_zero_len) else $error("zero length not reported");
   property p_word_count;
      (s.state == rrfp_pkg::st_eval && s.crc == s.hck && s.soh == rrfp_pkg::SOH_MARKER
       && s.rev == rrfp_pkg::REVISION && s.op == rrfp_pkg::OP_READ && s.len != 32'h0000_0000)
         |=> s.status == rrfp_pkg::ST_OK && s.words_left == $past(s.len[31:1]) && s.rd_index == $past(s.start);
   endproperty
   a_word_count: assert property (p_word_count) else $error("register count not half the length");
   property p_index_up;
      reg_rd_en |=> s.state == rrfp_pkg::st_dcap ##1 (s.rd_index == $past(s.rd_index) + 16'd1);
   endproperty
   a_index_up: assert property (p_index_up) else $error("register index did not step");
   property p_word_order;
      (s.state == rrfp_pkg::st_dhi && slot) |=> rsp_valid && rsp_data == $past(s.word[15:8]);
   endproperty
   a_word_order: assert property (p_word_order) else $error("high byte not first");
   property p_hdr_cksum;
      (s.state == rrfp_pkg::st_hdr && slot && s.idx == rrfp_pkg::OFS_HCK)
         |=> rsp_data == $past(s.crc[15:8]) && s.crc == $past(s.crc);
   endproperty
   a_hdr_cksum: assert property (p_hdr_cksum) else $error("header checksum byte wrong");
   property p_one_answer;
      (s.state == rrfp_pkg::st_rx && cmd_valid && s.idx == rrfp_pkg::OFS_HDR_LAST)
         |=> s.state == rrfp_pkg::st_eval ##1 (s.state == rrfp_pkg::st_hdr && s.idx == '0);
   endproperty
   a_one_answer: assert property (p_one_answer) else $error("frame end without answer");
   property p_timeout0;
      (s.active[0] && s.timer[0] == TMR_LAST && !conn_open)
         |=> s.timeout[0] && !s.active[0] ##1 !s.timeout[0];
   endproperty
   a_timeout0: assert property (p_timeout0) else $error("idle connection not closed");
   property p_net_hold;
      (net_wr && net_sel != rrfp_pkg::NET_APPLY_SEL) |=> net_active == $past(net_active);
   endproperty
   a_net_hold: assert property (p_net_hold) else $error("settings applied too early");

   c_read_ok:  cover property (s.state == rrfp_pkg::st_dlo && slot && s.words_left == '0);
   c_bad_ck:   cover property (s.state == rrfp_pkg::st_hdr && s.status == rrfp_pkg::ST_BAD_CKSUM);
   c_timeout:  cover property (|s.timeout);
   c_apply:    cover property (net_wr && net_sel == rrfp_pkg::NET_APPLY_SEL);
endmodule : rrfp_parser

// *** testbench/rrfp_host_model.sv ***
`timescale 1ns/1ps
module rrfp_host_model (
   // clock and pacing
   input  wire logic       core_clk,
   input  wire logic       slow,
   // command side
   output logic            cmd_valid,
   output logic [7:0]      cmd_data,
   output logic [2:0]      cmd_conn,
   input  wire logic       cmd_ready,
   // answer side
   input  wire logic       rsp_valid,
   input  wire logic [7:0] rsp_data,
   input  wire logic [2:0] rsp_conn,
   input  wire logic       rsp_last,
   output logic            rsp_ready
);
   logic [7:0] fr [64];
   logic [7:0] rb [256];
   int         rn;
   logic       got_last;
   logic [2:0] rc;
   int         hang;
   initial begin
      cmd_valid = 1'b0;
      cmd_data = 8'h00;
      cmd_conn = 3'h0;
      rsp_ready = 1'b1;
      hang = 0;
      rn = 0;
      got_last = 1'b0;
   end
   function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
      for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction : crc16
   // one read frame; bad flips the checksum's low bit
   task automatic send(input logic [2:0] id, input logic [15:0] mk, input logic [7:0] op,
                       input logic [31:0] len, input logic [15:0] st, input logic bad);
      logic [15:0] c;
      int          g;
      c = 16'h0000;
      for (int i = 0; i < 64; i++) fr[i] = 8'h5a; // ignored bytes carry junk, except 58 to 61, which are set to zero below
      {fr[0], fr[1]} = mk;
      fr[2] = 8'h03;
      fr[3] = op;
      {fr[8], fr[9], fr[10], fr[11]} = len;
      {fr[12], fr[13]} = st;
      {fr[58], fr[59], fr[60], fr[61]} = 32'h0;
      for (int i = 2; i < 62; i++) c = crc16(c, fr[i]);
      {fr[62], fr[63]} = c ^ {15'h0, bad};
      rn = 0;
      got_last = 1'b0;
      for (int i = 0; i < 64; i++) begin
         @(posedge core_clk);
         cmd_valid <= 1'b1;
         cmd_data <= fr[i];
         cmd_conn <= id;
         @(negedge core_clk);
         for (g = 0; g < 200 && cmd_ready !== 1'b1; g++) @(negedge core_clk);
         if (g == 200) hang++;
      end
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      cmd_data <= ~fr[63]; // released line must not look valid
   endtask : send
   always @(posedge core_clk) begin
      rsp_ready <= slow ? ~rsp_ready : 1'b1;
      if (rsp_valid && rsp_ready) begin
         rb[rn[7:0]] <= rsp_data;
         rn <= rn + 1;
         rc <= rsp_conn;
         if (rsp_last) got_last <= 1'b1;
      end
   end
endmodule : rrfp_host_model

// *** testbench/register_read_frame_parser_tb.sv ***
`timescale 1ns/1ps
module register_read_frame_parser_tb;
   logic core_clk = 0, rst_n = 0, slow = 0, cmd_valid, cmd_ready, rsp_valid, rsp_last, rsp_ready, reg_rd_en;
   logic conn_open = 0, conn_gone = 0, net_wr = 0;
   logic [7:0] cmd_data, rsp_data;
   logic [2:0] cmd_conn, rsp_conn, conn_id = 0, net_sel = 0;
   logic [15:0] reg_rd_index, reg_rd_data = 0, net_data = 0;
   logic [4:0] conn_active, conn_timeout;
   logic [95:0] net_active;
   int err_total = 0, comparisons = 0;
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) if (reg_rd_en) reg_rd_data <= reg_rd_index ^ 16'h5a5a;
   rrfp_parser #(.TIMEOUT_CYCLES(50)) dut (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_data(cmd_data), .cmd_conn(cmd_conn), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_conn(rsp_conn), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
      .reg_rd_en(reg_rd_en), .reg_rd_index(reg_rd_index), .reg_rd_data(reg_rd_data), .conn_open(conn_open),
      .conn_gone(conn_gone), .conn_id(conn_id), .conn_active(conn_active), .conn_timeout(conn_timeout),
      .net_wr(net_wr), .net_sel(net_sel), .net_data(net_data), .net_active(net_active));
   rrfp_host_model host (.core_clk(core_clk), .slow(slow), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
      .cmd_conn(cmd_conn), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_conn(rsp_conn), .rsp_last(rsp_last), .rsp_ready(rsp_ready));
   task automatic check(input logic [95:0] seen, input logic [95:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   // send one frame and judge the whole answer
   task automatic t_frame(input logic [2:0] id, input logic [15:0] mk, input logic [7:0] op,
                          input logic [31:0] len, input logic [15:0] st, input logic bad, input logic [7:0] es);
      logic [7:0] e [64];
      logic [15:0] c;
      int n, w;
      n = (es == 8'h00) ? int'(len[16:1]) : 0;
      host.send(id, mk, op, len, st, bad);
      for (w = 0; w < 4000 && host.got_last !== 1'b1; w++) @(posedge core_clk);
      if (w == 4000) begin
         err_total++;
         final_report();
      end
      for (int i = 0; i < 64; i++) e[i] = 8'h00;
      {e[0], e[1], e[2], e[3], e[5], e[7]} = {16'ha1ec, 8'h03, op, es, 8'h01};
      {e[8], e[9], e[10], e[11]} = 2 * n;
      {e[12], e[13]} = st;
      c = 16'h0000;
      for (int i = 2; i < 62; i++) c = host.crc16(c, e[i]);
      {e[62], e[63]} = c;
      for (int i = 0; i < 64; i++) check(host.rb[i], e[i]);
      for (int k = 0; k < n; k++) check({host.rb[64+2*k], host.rb[65+2*k]}, (st + k) ^ 16'h5a5a);
      check(host.rn, 64 + 2 * n);
      check(host.rc, id);
      check(host.hang, 0);
      $display("frame test status %h done", es);
   endtask : t_frame
   task automatic t_timeout;
      int t1, t3;
      t1 = -1;
      t3 = -1;
      for (int i = 0; i < 120; i++) begin
         @(posedge core_clk);
         conn_open <= (i == 0 || i == 20 || i == 100);
         conn_id <= (i < 20) ? 3'h0 : (i < 100) ? 3'h3 : 3'h4;
         conn_gone <= (i == 102);
         #1;
         if (conn_timeout[0] === 1'b1) t1 = i;
         if (conn_timeout[3] === 1'b1) t3 = i;
         if (i == 101) check(conn_active[4], 1);
         if (i == 104) check(conn_active[4], 0);
      end
      check(t3 - t1, 20);
      check(t1 >= 48 && t1 <= 56, 1);
      check(conn_active[3:0], 0);
      @(posedge core_clk);
      {conn_open, conn_id} <= {1'b1, 3'h2};
      @(posedge core_clk);
      conn_open <= 1'b0;
      // a frame outlasts the idle limit, yet every byte restarts the timer
      host.send(2, 16'ha1ec, 8'h03, 0, 16'h0010, 0);
      #1;
      check(conn_active[2], 1);
      $display("timeout test done");
   endtask : t_timeout
   task automatic t_net;
      for (int k = 0; k < 6; k++) begin
         @(posedge core_clk);
         {net_wr, net_sel, net_data} <= {1'b1, k[2:0], 16'h1000 + k[15:0]};
         #1;
         check(net_active, 96'h0);
      end
      @(posedge core_clk);
      net_wr <= 1'b0;
      @(posedge core_clk);
      #1;
      check(net_active, 96'h1005_1004_1003_1002_1001_1000);
      $display("network test done");
   endtask : t_net
   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      slow <= 1'b1;
      t_frame(0, 16'ha1ec, 8'h03, 4, 16'h1234, 0, 8'h00);
      slow <= 1'b0;
      t_frame(4, 16'ha1ec, 8'h03, 6, 16'h00fe, 0, 8'h00);
      t_frame(1, 16'ha1ec, 8'h03, 4, 16'h0010, 1, 8'hfb);
      t_frame(2, 16'ha1ec, 8'h03, 0, 16'h0010, 0, 8'hfd);
      t_frame(3, 16'ha1ec, 8'h05, 4, 16'h0010, 0, 8'hff);
      t_frame(3, 16'ha1ed, 8'h03, 4, 16'h0010, 0, 8'hff);
      t_timeout();
      t_net();
      final_report();
   end
endmodule : register_read_frame_parser_tb
